/* File: verilog/breaker_status_pkg.sv */
// Purpose: Shared constants and types for the breaker status register bank.
// Assumes: 16-bit register words, 250 MHz core clock.
// Notes: Time words use the 32.32 seconds/fraction format.
`default_nettype none
package breaker_status_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] MOTOR_OPERATOR_STATE_ADDR = 16'h5179;
  localparam logic [15:0] RESIDUAL_CURRENT_STATE_ADDR = 16'h517B;
  localparam logic [15:0] MOTOR_OPERATOR_COMMAND_ADDR = 16'h9C5E;
  localparam logic [15:0] SERVER_LINK_STATE_ADDR = 16'hF9E1;
  localparam logic [15:0] TIME_SEC_HI_ADDR = 16'hF000;
  localparam logic [15:0] TIME_SEC_LO_ADDR = 16'hF001;
  localparam logic [15:0] TIME_FRAC_HI_ADDR = 16'hF002;
  localparam logic [15:0] TIME_FRAC_LO_ADDR = 16'hF003;

  // ----------------------------------------------------------------------
  // Operator command codes
  // ----------------------------------------------------------------------
  localparam logic [15:0] CMD_SWITCH_ON = 16'h0815;
  localparam logic [15:0] CMD_SWITCH_OFF = 16'h0816;
  localparam logic [15:0] CMD_ACKNOWLEDGE = 16'h0817;

  // ----------------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250000000;
  // Fraction step per clock in units of 2^-64 s, rounded up.
  localparam logic [63:0] FRAC_STEP =
    64'(((65'h1 << 64) + 65'(CLK_HZ) - 65'h1) / 65'(CLK_HZ));
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  localparam logic [63:0] FRAC_RESET = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic alarm_level1;
    logic alarm_level2;
    logic internal_supply;
    logic external_supply;
    logic latch_unlatched;
    logic unit_fault;
    logic tripped;
    logic test_trip_button;
    logic test_trip_contact;
    logic test_trip_comm;
    logic spring_on_charged;
    logic spring_off_charged;
    logic [1:0] operation_mode;
    logic [1:0] reset_mode;
    logic operator_error;
    logic ack_done;
    logic config_set;
    logic config_valid;
    logic breaker_unreachable;
    logic breaker_connected;
    logic too_many_breakers;
  } breaker_inputs_t;

  typedef struct packed {
    logic switch_on;
    logic switch_off;
    logic acknowledge;
  } operator_pulses_t;

  typedef struct packed {
    logic [31:0] seconds;
    logic [31:0] fraction;
  } timestamp_t;

endpackage
`default_nettype wire

/* File: verilog/breaker_status_regs.sv */
// Purpose: Register bank for breaker, operator and data-server status.
// Assumes: Master reads and writes one 16-bit word per strobe.
// Notes: Breaker inputs are asynchronous and pass two flip-flops.
//
// Behaviour
// - Residual bits 0,1 show alarm levels one, two.
// - Residual bits 2-5 supply, latch, fault; 6-8 zero.
// - Residual bits 9-12 trip and three test trips.
// - Codes 2069/2070/2071 switch on, off, acknowledge.
// - Operator bits 8,9 show on/off spring charge.
// - Operator bits 10-11 give operation mode.
// - Operator bits 12-13 give reset mode.
// - Bit 14 error; bit 15 acknowledge pending.
// - Operator bits 0-7 always read zero.
// - Link bits 0,1 configuration set and valid.
// - Link bits 2-4 unreachable, connected, too many.
// - First time word counts seconds since 1970.
// - Second time word counts 2^-32 second units.
`timescale 1ns/10ps
`default_nettype none

module breaker_status_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register access
  input wire logic [15:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Breaker status pins
  input wire breaker_status_pkg::breaker_inputs_t breaker_in,
  // Operator commands and time
  output breaker_status_pkg::operator_pulses_t operator_cmd,
  output breaker_status_pkg::timestamp_t time_now
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    breaker_status_pkg::breaker_inputs_t meta;
    breaker_status_pkg::breaker_inputs_t sync;
    logic [15:0] rdata;
    logic rvalid;
    breaker_status_pkg::operator_pulses_t pulses;
    logic ack_pending;
    logic [15:0] sec_hi_stage;
    logic [31:0] seconds;
    logic [63:0] fraction;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [15:0] op_word;
  logic [15:0] rcu_word;
  logic [15:0] link_word;
  logic cmd_write;
  logic [64:0] frac_sum;

  // ----------------------------------------------------------------------
  // Register words
  // ----------------------------------------------------------------------
  always_comb begin
    op_word = {st_r.ack_pending, st_r.sync.operator_error, st_r.sync.reset_mode,
               st_r.sync.operation_mode,
               st_r.sync.spring_off_charged, st_r.sync.spring_on_charged,
               8'h00};
    rcu_word = {3'b000, st_r.sync.test_trip_comm, st_r.sync.test_trip_contact,
                st_r.sync.test_trip_button, st_r.sync.tripped, 3'b000,
                st_r.sync.unit_fault, st_r.sync.latch_unlatched,
                st_r.sync.external_supply, st_r.sync.internal_supply,
                st_r.sync.alarm_level2, st_r.sync.alarm_level1};
    link_word = {11'h000, st_r.sync.too_many_breakers, st_r.sync.breaker_connected,
                 st_r.sync.breaker_unreachable,
                 st_r.sync.config_valid, st_r.sync.config_set};
  end

  assign cmd_write = reg_write && (reg_addr == breaker_status_pkg::MOTOR_OPERATOR_COMMAND_ADDR);
  assign frac_sum = {1'b0, st_r.fraction} + {1'b0, breaker_status_pkg::FRAC_STEP};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = breaker_in;
    st_nxt.sync = st_r.meta;
    st_nxt.rvalid = reg_read;
    st_nxt.pulses = '0;
    // Time advances every clock; the carry out of the fraction is one second.
    st_nxt.fraction = frac_sum[63:0];
    st_nxt.seconds = st_r.seconds + {31'h0, frac_sum[64]};
    if (reg_read) begin
      unique case (reg_addr)
        breaker_status_pkg::MOTOR_OPERATOR_STATE_ADDR: st_nxt.rdata = op_word;
        breaker_status_pkg::RESIDUAL_CURRENT_STATE_ADDR: st_nxt.rdata = rcu_word;
        breaker_status_pkg::SERVER_LINK_STATE_ADDR: st_nxt.rdata = link_word;
        breaker_status_pkg::TIME_SEC_HI_ADDR: st_nxt.rdata = st_r.seconds[31:16];
        breaker_status_pkg::TIME_SEC_LO_ADDR: st_nxt.rdata = st_r.seconds[15:0];
        breaker_status_pkg::TIME_FRAC_HI_ADDR: st_nxt.rdata = st_r.fraction[63:48];
        breaker_status_pkg::TIME_FRAC_LO_ADDR: st_nxt.rdata = st_r.fraction[47:32];
        default: st_nxt.rdata = breaker_status_pkg::WORD_RESET;
      endcase
    end
    // Seconds load as one unit on the low-word write so a read never sees half.
    if (reg_write && reg_addr == breaker_status_pkg::TIME_SEC_HI_ADDR) begin
      st_nxt.sec_hi_stage = reg_wdata;
    end
    if (reg_write && reg_addr == breaker_status_pkg::TIME_SEC_LO_ADDR) begin
      st_nxt.seconds = {st_r.sec_hi_stage, reg_wdata};
      st_nxt.fraction = breaker_status_pkg::FRAC_RESET;
    end
    if (st_r.sync.ack_done) begin
      st_nxt.ack_pending = 1'b0;
    end
    if (cmd_write) begin
      unique case (reg_wdata)
        breaker_status_pkg::CMD_SWITCH_ON: st_nxt.pulses.switch_on = 1'b1;
        breaker_status_pkg::CMD_SWITCH_OFF: st_nxt.pulses.switch_off = 1'b1;
        breaker_status_pkg::CMD_ACKNOWLEDGE: begin
          st_nxt.pulses.acknowledge = 1'b1;
          st_nxt.ack_pending = 1'b1;
        end
        default: st_nxt.pulses = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign operator_cmd = st_r.pulses;
  assign time_now = '{seconds: st_r.seconds, fraction: st_r.fraction[63:32]};

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence on_cmd_s;
    cmd_write && reg_wdata == breaker_status_pkg::CMD_SWITCH_ON;
  endsequence

  sequence ack_cmd_s;
    cmd_write && reg_wdata == breaker_status_pkg::CMD_ACKNOWLEDGE;
  endsequence

  switch_on_cmd_a: assert property (@(posedge clock) disable iff (rst)
    on_cmd_s |=> operator_cmd.switch_on && !operator_cmd.switch_off
    ##1 (!operator_cmd.switch_on
    || $past(cmd_write && reg_wdata == breaker_status_pkg::CMD_SWITCH_ON)))
    else $error("switch-on command did not give a single pulse");

  switch_off_cmd_a: assert property (@(posedge clock) disable iff (rst)
    cmd_write && reg_wdata == breaker_status_pkg::CMD_SWITCH_OFF
    |=> operator_cmd.switch_off && !operator_cmd.switch_on)
    else $error("switch-off command did not pulse");

  ack_pending_set_a: assert property (@(posedge clock) disable iff (rst)
    ack_cmd_s |=> operator_cmd.acknowledge && st_r.ack_pending)
    else $error("acknowledge did not pulse or set pending");

  ack_pending_clear_a: assert property (@(posedge clock) disable iff (rst)
    st_r.sync.ack_done && !(cmd_write && reg_wdata == breaker_status_pkg::CMD_ACKNOWLEDGE)
    |=> !st_r.ack_pending)
    else $error("pending flag not cleared by acknowledge done");

  bad_cmd_ignored_a: assert property (@(posedge clock) disable iff (rst)
    cmd_write && reg_wdata != breaker_status_pkg::CMD_SWITCH_ON
    && reg_wdata != breaker_status_pkg::CMD_SWITCH_OFF
    && reg_wdata != breaker_status_pkg::CMD_ACKNOWLEDGE |=> operator_cmd == '0)
    else $error("undefined command code produced a pulse");

  op_read_a: assert property (@(posedge clock) disable iff (rst)
    reg_read && reg_addr == breaker_status_pkg::MOTOR_OPERATOR_STATE_ADDR
    |=> reg_rvalid && reg_rdata[7:0] == 8'h00
    && reg_rdata[11:10] == $past(st_r.sync.operation_mode))
    else $error("operator status read wrong");

  rcu_read_a: assert property (@(posedge clock) disable iff (rst)
    reg_read && reg_addr == breaker_status_pkg::RESIDUAL_CURRENT_STATE_ADDR
    |=> reg_rdata[9] == $past(st_r.sync.tripped) && reg_rdata[0] == $past(st_r.sync.alarm_level1)
    && reg_rdata[8:6] == 3'b000)
    else $error("residual-current status read wrong");

  link_read_a: assert property (@(posedge clock) disable iff (rst)
    reg_read && reg_addr == breaker_status_pkg::SERVER_LINK_STATE_ADDR
    |=> reg_rdata[15:5] == 11'h000 && reg_rdata[4] == $past(st_r.sync.too_many_breakers))
    else $error("link status read wrong");

  link_cfg_a: assert property (@(posedge clock) disable iff (rst)
    reg_read && reg_addr == breaker_status_pkg::SERVER_LINK_STATE_ADDR
    |=> reg_rdata[0] == $past(st_r.sync.config_set)
    && reg_rdata[1] == $past(st_r.sync.config_valid)
    && reg_rdata[2] == $past(st_r.sync.breaker_unreachable)
    && reg_rdata[3] == $past(st_r.sync.breaker_connected))
    else $error("link configuration or reach bits read wrong");

  supply_bits_a: assert property (@(posedge clock) disable iff (rst)
    reg_read && reg_addr == breaker_status_pkg::RESIDUAL_CURRENT_STATE_ADDR
    |=> reg_rdata[2] == $past(st_r.sync.internal_supply)
    && reg_rdata[3] == $past(st_r.sync.external_supply)
    && reg_rdata[4] == $past(st_r.sync.latch_unlatched)
    && reg_rdata[5] == $past(st_r.sync.unit_fault))
    else $error("residual-current supply or fault bits read wrong");

  spring_bits_a: assert property (@(posedge clock) disable iff (rst)
    reg_read && reg_addr == breaker_status_pkg::MOTOR_OPERATOR_STATE_ADDR
    |=> reg_rdata[8] == $past(st_r.sync.spring_on_charged)
    && reg_rdata[9] == $past(st_r.sync.spring_off_charged))
    else $error("operator spring bits read wrong");

  reset_mode_a: assert property (@(posedge clock) disable iff (rst)
    reg_read && reg_addr == breaker_status_pkg::MOTOR_OPERATOR_STATE_ADDR
    |=> reg_rdata[13:12] == $past(st_r.sync.reset_mode))
    else $error("operator reset mode read wrong");

  error_pending_a: assert property (@(posedge clock) disable iff (rst)
    reg_read && reg_addr == breaker_status_pkg::MOTOR_OPERATOR_STATE_ADDR
    |=> reg_rdata[14] == $past(st_r.sync.operator_error)
    && reg_rdata[15] == $past(st_r.ack_pending))
    else $error("operator error or pending bit read wrong");

  rvalid_pulse_a: assert property (@(posedge clock) disable iff (rst)
    reg_read |=> reg_rvalid)
    else $error("read was not answered one cycle later");

  rvalid_idle_a: assert property (@(posedge clock) disable iff (rst)
    !reg_read |=> !reg_rvalid)
    else $error("read valid stood without a read");

  // The wrap is a full second away, so a run only exercises the hold case below.
  seconds_tick_a: assert property (@(posedge clock) disable iff (rst)
    !reg_write
    && st_r.fraction > 64'hFFFF_FFFF_FFFF_FFFF - breaker_status_pkg::FRAC_STEP
    |=> time_now.seconds == $past(time_now.seconds) + 32'h0000_0001)
    else $error("seconds did not advance on fraction wrap");

  seconds_hold_a: assert property (@(posedge clock) disable iff (rst)
    !reg_write
    && st_r.fraction <= 64'hFFFF_FFFF_FFFF_FFFF - breaker_status_pkg::FRAC_STEP
    |=> $stable(time_now.seconds))
    else $error("seconds moved without a fraction wrap");

  frac_step_a: assert property (@(posedge clock) disable iff (rst)
    !reg_write ##1 !reg_write && $past(st_r.fraction) <= 64'hFFFF_FFF0_0000_0000
    |-> st_r.fraction == $past(st_r.fraction) + breaker_status_pkg::FRAC_STEP)
    else $error("fraction did not advance by one clock step");

endmodule

`default_nettype wire

/* File: verif/reg_master_model.sv */
// Purpose: Bus master model for the breaker register bank.
// Assumes: One word per strobe; read data comes one cycle after the strobe.
// Notes: Released address and data lines show the inverse of the last value.
`timescale 1ns/10ps
`default_nettype none
module reg_master_model (
  // Clock
  input wire logic clock,
  // Register access
  output logic [15:0] reg_addr,
  output logic reg_write,
  output logic reg_read,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output bit ok);
    ok = 1'b0;
    d = 16'h0000;
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clock);
      ok = reg_rvalid;
      d = reg_rdata;
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench for the breaker register bank.
// Assumes: Inputs change at the rising edge by non-blocking assignment.
// Notes: Expected words are built from the input struct, never read back.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock;
  logic rst;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_write, reg_read, reg_rvalid;
  breaker_status_pkg::breaker_inputs_t brk;
  breaker_status_pkg::operator_pulses_t operator_cmd;
  breaker_status_pkg::timestamp_t time_now;
  int err_total = 0;
  int n_compared = 0;
  logic [15:0] codes [5] = '{16'h0815, 16'h0816, 16'h0817, 16'h0814, 16'h0818};
  logic [2:0] pulses [5] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h0};
  logic [31:0] f1;
  logic [15:0] d16;
  bit rd_ok;

  breaker_status_regs i_breaker_status_regs (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .breaker_in(brk), .operator_cmd(operator_cmd),
    .time_now(time_now));
  reg_master_model i_reg_master_model (.clock(clock), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  function automatic logic [15:0] exp_rc(breaker_status_pkg::breaker_inputs_t b);
    return {3'h0, b.test_trip_comm, b.test_trip_contact, b.test_trip_button, b.tripped, 3'h0,
      b.unit_fault, b.latch_unlatched, b.external_supply, b.internal_supply,
      b.alarm_level2, b.alarm_level1};
  endfunction
  function automatic logic [15:0] exp_op(breaker_status_pkg::breaker_inputs_t b, logic p);
    return {p, b.operator_error, b.reset_mode, b.operation_mode, b.spring_off_charged,
      b.spring_on_charged, 8'h00};
  endfunction
  function automatic logic [15:0] exp_link(breaker_status_pkg::breaker_inputs_t b);
    return {11'h000, b.too_many_breakers, b.breaker_connected, b.breaker_unreachable,
      b.config_valid, b.config_set};
  endfunction

  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] e, input string what);
    logic [15:0] d;
    bit ok;
    i_reg_master_model.rd(a, d, ok);
    if (!ok) begin
      err_total++;
      $display("unexpected at %0t: no read answer", $time);
      close_out();
    end else
      chk({16'h0000, d}, {16'h0000, e}, what);
  endtask

  initial begin
    rst = 1'b1;
    brk = '0;
    void'($urandom(74));
    repeat (12) @(posedge clock);
    chk(time_now.seconds, 32'h0, "seconds in reset");
    chk(time_now.fraction, 32'h0, "fraction in reset");
    rst <= 1'b0;
    for (int n = 0; n < 24; n++) begin
      @(posedge clock);
      brk <= breaker_status_pkg::breaker_inputs_t'(23'($urandom));
      repeat (4) @(posedge clock);
      rdc(breaker_status_pkg::RESIDUAL_CURRENT_STATE_ADDR, exp_rc(brk), "rc");
      rdc(breaker_status_pkg::MOTOR_OPERATOR_STATE_ADDR, exp_op(brk, 1'b0), "op");
      rdc(breaker_status_pkg::SERVER_LINK_STATE_ADDR, exp_link(brk), "link");
    end
    i_reg_master_model.wr(breaker_status_pkg::RESIDUAL_CURRENT_STATE_ADDR, 16'hFFFF);
    rdc(breaker_status_pkg::RESIDUAL_CURRENT_STATE_ADDR, exp_rc(brk), "ro write");
    rdc(16'h1234, 16'h0000, "unmapped");
    $display("test status done");
    brk.ack_done <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      i_reg_master_model.wr(breaker_status_pkg::MOTOR_OPERATOR_COMMAND_ADDR, codes[k]);
      @(posedge clock);
      chk({29'h0, operator_cmd}, {29'h0, pulses[k]}, "pulse");
      @(posedge clock);
      chk({29'h0, operator_cmd}, 32'h0, "pulse end");
    end
    rdc(breaker_status_pkg::MOTOR_OPERATOR_STATE_ADDR, exp_op(brk, 1'b1), "pending");
    brk.ack_done <= 1'b1;
    repeat (4) @(posedge clock);
    rdc(breaker_status_pkg::MOTOR_OPERATOR_STATE_ADDR, exp_op(brk, 1'b0), "acked");
    $display("test command done");
    f1 = time_now.fraction;
    repeat (100) @(posedge clock);
    f1 = time_now.fraction - f1;
    chk({31'h0, f1 == 32'h6B5 || f1 == 32'h6B6}, 32'h1, "fraction rate");
    i_reg_master_model.wr(breaker_status_pkg::TIME_SEC_HI_ADDR, 16'h1234);
    i_reg_master_model.wr(breaker_status_pkg::TIME_SEC_LO_ADDR, 16'h5678);
    @(posedge clock);
    chk(time_now.seconds, 32'h12345678, "seconds");
    chk({31'h0, time_now.fraction < 32'h00001000}, 32'h1, "fraction zeroed");
    rdc(breaker_status_pkg::TIME_SEC_HI_ADDR, 16'h1234, "sec hi");
    rdc(breaker_status_pkg::TIME_SEC_LO_ADDR, 16'h5678, "sec lo");
    rdc(breaker_status_pkg::TIME_FRAC_HI_ADDR, 16'h0000, "frac hi");
    i_reg_master_model.rd(breaker_status_pkg::TIME_FRAC_LO_ADDR, d16, rd_ok);
    chk({31'h0, rd_ok && d16 > 16'h0000 && d16 < 16'h0400}, 32'h1, "frac lo");
    $display("test time done");
    close_out();
  end
endmodule
`default_nettype wire
